// file: hw/mem_event_pkg.sv
// Purpose: Shared constants for the memory-pipeline event selection block
// Assumes: Event-select and counter-config words are 32 bits wide
// Notes:   Field positions, event codes and counter-config selects
package mem_event_pkg;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CODE_MSB = 31;
  localparam int CODE_LSB = 25;
  localparam int MASK_MSB = 24;
  localparam int MASK_LSB = 9;
  localparam int CSEL_MSB = 15;
  localparam int CSEL_LSB = 13;
  localparam int MASK_W   = MASK_MSB - MASK_LSB + 1;

  // ****************************************
  // Event-select codes
  // ****************************************
  localparam logic [6:0] CODE_MEM_COMPLETE = 7'h08;
  localparam logic [6:0] CODE_LOAD_REPLAY  = 7'h04;
  localparam logic [6:0] CODE_STORE_REPLAY = 7'h05;
  localparam logic [6:0] CODE_ORDER_RETRY  = 7'h03;
  localparam logic [6:0] CODE_PAGE_WALK    = 7'h01;

  // ****************************************
  // Counter-config selects
  // ****************************************
  localparam logic [2:0] CSEL_STORE_ADDR = 3'h2;
  localparam logic [2:0] CSEL_ORDER_BUF  = 3'h2;
  localparam logic [2:0] CSEL_WALK       = 3'h4;

  // ****************************************
  // Mask bit positions
  // ****************************************
  localparam int BIT_LOAD_SPLIT   = 0;
  localparam int BIT_STORE_SPLIT  = 1;
  localparam int BIT_SPLIT_LOAD   = 1;
  localparam int BIT_SPLIT_STORE  = 1;
  localparam int BIT_NO_STA       = 1;
  localparam int BIT_NO_STD       = 3;
  localparam int BIT_PARTIAL_DATA = 4;
  localparam int BIT_UNALIGNED    = 5;
  localparam int BIT_DATA_WALK    = 0;
  localparam int BIT_INSTR_WALK   = 1;

  // ****************************************
  // Counter numbering
  // ****************************************
  localparam int NUM_COUNTERS  = 12;
  localparam int CNT_LOW_A     = 0;
  localparam int CNT_LOW_B     = 2;
  localparam int CNT_STORE_A   = 8;
  localparam int CNT_STORE_B   = 10;

endpackage

// file: hw/event_qualify.sv
// Purpose: Match one event-select word against one event and its mask bits
// Assumes: Event vector is laid out on the mask bit positions
// Notes:   Purely combinational
`timescale 1ns/1ps
module event_qualify
  import mem_event_pkg::*;
(
  // Programmed selection
  input  wire logic [31:0]       evsel,
  input  wire logic [6:0]        code,
  // Event strobes on mask positions
  input  wire logic [MASK_W-1:0] events,
  // Result
  output logic                   hit
);

  // Any selected mask bit with its event present counts; empty mask counts nothing
  assign hit = (evsel[CODE_MSB:CODE_LSB] == code) && |(evsel[MASK_MSB:MASK_LSB] & events);

endmodule

// file: hw/mem_replay_event_select.sv
// Purpose: Route memory-pipeline events to performance counter increments
// Assumes: Event strobes are one-cycle pulses synchronous to mclk
// Notes:   Counter arithmetic lives outside; this block issues increments
// Behaviour
// - Code 08H with counter select 02H counts load split and store split completions
// - Mask bit 0 load splits done, bit 1 store splits done
// - Several mask bits may be set; any matching bit counts
// - Store-address pair: first word feeds counters 8,9; second feeds 10,11
// - Code 04H, mask bit 1, select 02H counts split load replays
// - Code 05H, mask bit 1, select 02H counts split store replays
// - Order-buffer load retries route to counters 0,1 or 2,3
// - All-cache-miss qualification also counts uncacheable accesses
// - Code 01H counts page walks; bit 0 data, bit 1 instruction
`timescale 1ns/1ps
module mem_replay_event_select
  import mem_event_pkg::*;
(
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // Event-select words
  input  wire logic [31:0]                  store_addr_evsel_a,
  input  wire logic [31:0]                  store_addr_evsel_b,
  input  wire logic [31:0]                  order_buf_evsel_a,
  input  wire logic [31:0]                  order_buf_evsel_b,
  input  wire logic [31:0]                  walk_evsel_a,
  input  wire logic [31:0]                  walk_evsel_b,
  // Counter-config words, one per counter
  input  wire logic [NUM_COUNTERS-1:0][31:0] counter_config_ctrl,
  // Memory completion strobes
  input  wire logic                         load_split_done,
  input  wire logic                         store_split_done,
  // Port replay strobes
  input  wire logic                         split_load_replay,
  input  wire logic                         split_store_replay,
  // Order-buffer retry causes
  input  wire logic                         retry_no_sta,
  input  wire logic                         retry_no_std,
  input  wire logic                         retry_partial_data,
  input  wire logic                         retry_unaligned,
  // Page-miss walker strobes
  input  wire logic                         data_xlate_miss_walk,
  input  wire logic                         instr_xlate_miss_walk,
  // Cache event qualification
  input  wire logic                         all_miss_enable,
  input  wire logic                         cache_miss,
  input  wire logic                         uncacheable_access,
  // Results
  output logic [NUM_COUNTERS-1:0]           count_inc,
  output logic                              all_cache_miss_event
);

  // ****************************************
  // Event vectors on mask positions
  // ****************************************
  logic [MASK_W-1:0] complete_vec;
  logic [MASK_W-1:0] load_rep_vec;
  logic [MASK_W-1:0] store_rep_vec;
  logic [MASK_W-1:0] retry_vec;
  logic [MASK_W-1:0] walk_vec;

  always_comb begin
    complete_vec                   = '0;
    complete_vec[BIT_LOAD_SPLIT]   = load_split_done;
    complete_vec[BIT_STORE_SPLIT]  = store_split_done;
    load_rep_vec                   = '0;
    load_rep_vec[BIT_SPLIT_LOAD]   = split_load_replay;
    store_rep_vec                  = '0;
    store_rep_vec[BIT_SPLIT_STORE] = split_store_replay;
    retry_vec                      = '0;
    retry_vec[BIT_NO_STA]          = retry_no_sta;
    retry_vec[BIT_NO_STD]          = retry_no_std;
    retry_vec[BIT_PARTIAL_DATA]    = retry_partial_data;
    retry_vec[BIT_UNALIGNED]       = retry_unaligned;
    walk_vec                       = '0;
    walk_vec[BIT_DATA_WALK]        = data_xlate_miss_walk;
    walk_vec[BIT_INSTR_WALK]       = instr_xlate_miss_walk;
  end

  // ****************************************
  // Per-pair qualification
  // ****************************************
  logic [31:0] sa_word [2];
  logic [31:0] ob_word [2];
  logic [31:0] wk_word [2];
  logic [1:0]  sa_hit;
  logic [1:0]  ob_hit;
  logic [1:0]  wk_hit;
  logic [2:0]  csel [NUM_COUNTERS];

  assign sa_word[0] = store_addr_evsel_a;
  assign sa_word[1] = store_addr_evsel_b;
  assign ob_word[0] = order_buf_evsel_a;
  assign ob_word[1] = order_buf_evsel_b;
  assign wk_word[0] = walk_evsel_a;
  assign wk_word[1] = walk_evsel_b;

  for (genvar k = 0; k < NUM_COUNTERS; k++) begin : g_csel
    assign csel[k] = counter_config_ctrl[k][CSEL_MSB:CSEL_LSB];
  end

  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic mc_hit;
    logic lr_hit;
    logic sr_hit;

    event_qualify u_complete (
      .evsel  (sa_word[p]),
      .code   (CODE_MEM_COMPLETE),
      .events (complete_vec),
      .hit    (mc_hit)
    );
    event_qualify u_load_rep (
      .evsel  (sa_word[p]),
      .code   (CODE_LOAD_REPLAY),
      .events (load_rep_vec),
      .hit    (lr_hit)
    );
    event_qualify u_store_rep (
      .evsel  (sa_word[p]),
      .code   (CODE_STORE_REPLAY),
      .events (store_rep_vec),
      .hit    (sr_hit)
    );
    event_qualify u_retry (
      .evsel  (ob_word[p]),
      .code   (CODE_ORDER_RETRY),
      .events (retry_vec),
      .hit    (ob_hit[p])
    );
    event_qualify u_walk (
      .evsel  (wk_word[p]),
      .code   (CODE_PAGE_WALK),
      .events (walk_vec),
      .hit    (wk_hit[p])
    );

    // Only one code can match a word, so the OR never double counts
    assign sa_hit[p] = mc_hit | lr_hit | sr_hit;
  end

  // ****************************************
  // Counter increment routing
  // ****************************************
  logic [NUM_COUNTERS-1:0] next_count_inc;
  logic                    next_all_cache_miss_event;

  always_comb begin
    next_count_inc = '0;
    for (int i = 0; i < 2; i++) begin
      // Store-address pair is the only path into counters 8 to 11
      next_count_inc[CNT_STORE_A+i] = sa_hit[0] && (csel[CNT_STORE_A+i] == CSEL_STORE_ADDR);
      next_count_inc[CNT_STORE_B+i] = sa_hit[1] && (csel[CNT_STORE_B+i] == CSEL_STORE_ADDR);
      // Low counters pick their source word by the counter-config select
      next_count_inc[CNT_LOW_A+i] = (ob_hit[0] && (csel[CNT_LOW_A+i] == CSEL_ORDER_BUF))
                                  | (wk_hit[0] && (csel[CNT_LOW_A+i] == CSEL_WALK));
      next_count_inc[CNT_LOW_B+i] = (ob_hit[1] && (csel[CNT_LOW_B+i] == CSEL_ORDER_BUF))
                                  | (wk_hit[1] && (csel[CNT_LOW_B+i] == CSEL_WALK));
    end
    // Uncacheable accesses miss by definition, so they join the miss count
    next_all_cache_miss_event = all_miss_enable && (cache_miss || uncacheable_access);
  end

  // Registered to keep outputs glitch free; costs one cycle of latency
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_inc            <= '0;
      all_cache_miss_event <= 1'b0;
    end else begin
      count_inc            <= next_count_inc;
      all_cache_miss_event <= next_all_cache_miss_event;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence sa_a_complete_s;
    store_addr_evsel_a[CODE_MSB:CODE_LSB] == CODE_MEM_COMPLETE && csel[CNT_STORE_A] == CSEL_STORE_ADDR;
  endsequence

  sequence load_split_seen_s;
    load_split_done && store_addr_evsel_a[MASK_LSB+BIT_LOAD_SPLIT];
  endsequence

  complete_count_a: assert property ((sa_a_complete_s and load_split_seen_s) |=> count_inc[CNT_STORE_A])
    else $error("load split completion not counted on counter 8");

  store_split_a: assert property (
    (store_addr_evsel_b[CODE_MSB:CODE_LSB] == CODE_MEM_COMPLETE && csel[CNT_STORE_B+1] == CSEL_STORE_ADDR
     && store_split_done && store_addr_evsel_b[MASK_LSB+BIT_STORE_SPLIT]) |=> count_inc[CNT_STORE_B+1])
    else $error("store split completion not counted on counter 11");

  mask_only_a: assert property (
    (store_addr_evsel_a[CODE_MSB:CODE_LSB] == CODE_MEM_COMPLETE && !store_addr_evsel_a[MASK_LSB+BIT_LOAD_SPLIT]
     && !store_split_done) |=> !count_inc[CNT_STORE_A])
    else $error("unselected mask bit was counted");

  pair_route_a: assert property (count_inc[CNT_STORE_B] |->
    $past(csel[CNT_STORE_B] == CSEL_STORE_ADDR && store_addr_evsel_b[MASK_MSB:MASK_LSB] != '0))
    else $error("counter 10 counted without second store-address word");

  unused_cnt_a: assert property (count_inc[7:4] == 4'h0)
    else $error("counters 4 to 7 must never count");

  load_replay_a: assert property (
    (store_addr_evsel_b[CODE_MSB:CODE_LSB] == CODE_LOAD_REPLAY && store_addr_evsel_b[MASK_LSB+BIT_SPLIT_LOAD]
     && split_load_replay && csel[CNT_STORE_B] == CSEL_STORE_ADDR) |=> count_inc[CNT_STORE_B])
    else $error("split load replay not counted");

  store_replay_a: assert property (
    (store_addr_evsel_a[CODE_MSB:CODE_LSB] == CODE_STORE_REPLAY && store_addr_evsel_a[MASK_LSB+BIT_SPLIT_STORE]
     && split_store_replay && csel[CNT_STORE_A+1] == CSEL_STORE_ADDR) |=> count_inc[CNT_STORE_A+1])
    else $error("split store replay not counted");

  retry_route_a: assert property (
    (order_buf_evsel_b[CODE_MSB:CODE_LSB] == CODE_ORDER_RETRY && order_buf_evsel_b[MASK_LSB+BIT_NO_STD]
     && retry_no_std && csel[CNT_LOW_B] == CSEL_ORDER_BUF) |=> count_inc[CNT_LOW_B])
    else $error("order buffer load retry not counted on counter 2");

  uc_miss_a: assert property ((all_miss_enable && uncacheable_access) |=> all_cache_miss_event)
    else $error("uncacheable access missing from all-miss count");

  walk_count_a: assert property (
    (walk_evsel_a[CODE_MSB:CODE_LSB] == CODE_PAGE_WALK && walk_evsel_a[MASK_LSB+BIT_INSTR_WALK]
     && instr_xlate_miss_walk && csel[CNT_LOW_A+1] == CSEL_WALK) |=> count_inc[CNT_LOW_A+1])
    else $error("instruction walk not counted on counter 1");

  select_gate_a: assert property (
    (csel[CNT_STORE_A] != CSEL_STORE_ADDR || store_addr_evsel_a[MASK_MSB:MASK_LSB] == '0)
    |=> !count_inc[CNT_STORE_A])
    else $error("counter 8 counted with wrong select or empty mask");

endmodule

// file: dv/mem_pipe_model.sv
// Purpose: Memory pipeline model raising event strobes
// Assumes: One request bit per strobe, order as wired in the bench
// Notes:   Strobes are one-cycle pulses launched on the mclk edge
`timescale 1ns/1ps
module mem_pipe_model (
  // Clock
  input  wire logic        mclk,
  // Requests from the bench
  input  wire logic [11:0] req,
  // Event strobes
  output logic [11:0]      strobe
);
  // ****************************************
  // Strobe launch
  // ****************************************
  // Registered so a strobe never changes between edges
  always @(posedge mclk) begin
    strobe <= req;
  end
endmodule

// file: dv/mem_replay_event_select_tb.sv
// Purpose: Self-checking bench for memory event selection
// Assumes: Increment appears exactly one cycle after the sampled strobe
// Notes:   Strobe bits follow the port order of the block
`timescale 1ns/1ps
module mem_replay_event_select_tb;
  import mem_event_pkg::*;
  logic                          mclk = 1'b0;
  logic                          rst  = 1'b1;
  logic [31:0]                   sa_a, sa_b, ob_a, ob_b, wk_a, wk_b;
  logic [NUM_COUNTERS-1:0][31:0] ccc;
  logic [11:0]                   req, strobe;
  logic                          all_miss_enable;
  logic [NUM_COUNTERS-1:0]       count_inc;
  logic                          all_cache_miss_event;
  int                            n_fail   = 0;
  int                            n_checks = 0;

  // ****************************************
  // Clock, partner and block
  // ****************************************
  initial forever #5 mclk = ~mclk;
  mem_pipe_model u_mem_pipe_model (.mclk(mclk), .req(req), .strobe(strobe));
  mem_replay_event_select u_mem_replay_event_select (
    .mclk(mclk), .rst(rst),
    .store_addr_evsel_a(sa_a), .store_addr_evsel_b(sa_b),
    .order_buf_evsel_a(ob_a), .order_buf_evsel_b(ob_b),
    .walk_evsel_a(wk_a), .walk_evsel_b(wk_b), .counter_config_ctrl(ccc),
    .load_split_done(strobe[0]), .store_split_done(strobe[1]),
    .split_load_replay(strobe[2]), .split_store_replay(strobe[3]),
    .retry_no_sta(strobe[4]), .retry_no_std(strobe[5]),
    .retry_partial_data(strobe[6]), .retry_unaligned(strobe[7]),
    .data_xlate_miss_walk(strobe[8]), .instr_xlate_miss_walk(strobe[9]),
    .all_miss_enable(all_miss_enable), .cache_miss(strobe[10]),
    .uncacheable_access(strobe[11]),
    .count_inc(count_inc), .all_cache_miss_event(all_cache_miss_event));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] ev(input logic [6:0] c, input logic [15:0] m);
    return {c, m, 9'h000};
  endfunction
  function automatic logic [31:0] sel(input logic [2:0] s);
    return {16'h0000, s, 13'h0000};
  endfunction
  task automatic clr();
    {sa_a, sa_b, ob_a, ob_b, wk_a, wk_b} = '0;
    ccc = '0;
    all_miss_enable = 1'b0;
  endtask
  // One pulse through the partner; checked the cycle after the block samples it
  task automatic shot(input logic [11:0] r, input logic [12:0] exp);
    req = r;
    @(posedge mclk);
    #1 req = 12'h000;
    @(posedge mclk);
    #1 n_checks++;
    if ({all_cache_miss_event, count_inc} !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, {all_cache_miss_event, count_inc}, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_complete();
    clr();
    sa_a = ev(CODE_MEM_COMPLETE, 16'h0001);
    for (int k = 8; k < 10; k++) ccc[k] = sel(CSEL_STORE_ADDR);
    shot(12'h001, 13'h0300);
    shot(12'h002, 13'h0000);
  endtask
  task automatic t_multi();
    clr();
    sa_b = ev(CODE_MEM_COMPLETE, 16'h0003);
    for (int k = 10; k < 12; k++) ccc[k] = sel(CSEL_STORE_ADDR);
    shot(12'h003, 13'h0c00);
    shot(12'h002, 13'h0c00);
  endtask
  task automatic t_replay();
    clr();
    sa_b = ev(CODE_LOAD_REPLAY, 16'h0002);
    for (int k = 10; k < 12; k++) ccc[k] = sel(CSEL_STORE_ADDR);
    shot(12'h004, 13'h0c00);
    shot(12'h008, 13'h0000);
    sa_b = ev(CODE_STORE_REPLAY, 16'h0002);
    shot(12'h008, 13'h0c00);
    shot(12'h004, 13'h0000);
    // First word of the pair counts replays too, on its own counters
    sa_a = ev(CODE_STORE_REPLAY, 16'h0002);
    for (int k = 8; k < 10; k++) ccc[k] = sel(CSEL_STORE_ADDR);
    shot(12'h008, 13'h0f00);
  endtask
  task automatic t_refuse();
    clr();
    sa_a = ev(CODE_MEM_COMPLETE, 16'h0001);
    ccc[8] = sel(3'h3);
    shot(12'h001, 13'h0000);
    ccc[8] = sel(CSEL_STORE_ADDR);
    sa_a = ev(CODE_MEM_COMPLETE, 16'h0000);
    shot(12'h003, 13'h0000);
  endtask
  task automatic t_order();
    clr();
    ob_a = ev(CODE_ORDER_RETRY, 16'h0002);
    ob_b = ev(CODE_ORDER_RETRY, 16'h0038);
    for (int k = 0; k < 4; k++) ccc[k] = sel(CSEL_ORDER_BUF);
    shot(12'h010, 13'h0003);
    shot(12'h0c0, 13'h000c);
    shot(12'h020, 13'h000c);
  endtask
  task automatic t_walk();
    clr();
    wk_a = ev(CODE_PAGE_WALK, 16'h0001);
    wk_b = ev(CODE_PAGE_WALK, 16'h0002);
    ob_a = ev(CODE_ORDER_RETRY, 16'h0002);
    for (int k = 0; k < 4; k++) ccc[k] = sel(CSEL_WALK);
    shot(12'h300, 13'h000f);
    shot(12'h010, 13'h0000);
    // Swap the first word to the instruction bit alone
    wk_a = ev(CODE_PAGE_WALK, 16'h0002);
    shot(12'h100, 13'h0000);
    shot(12'h200, 13'h000f);
  endtask
  task automatic t_allmiss();
    clr();
    all_miss_enable = 1'b1;
    shot(12'h800, 13'h1000);
    shot(12'h400, 13'h1000);
    all_miss_enable = 1'b0;
    shot(12'h800, 13'h0000);
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    req = 12'h000;
    clr();
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    shot(12'h000, 13'h0000);
    t_complete();
    t_multi();
    t_replay();
    t_refuse();
    t_order();
    t_walk();
    t_allmiss();
    conclude();
  end
  // Whole run is well under a microsecond of traffic
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule
